// file: rtl/pzs_pkg.sv
/*
 * Shared constants, enumerations and carriers of the piezo setpoint panel
 * controller. Voltages are held in millivolts, unsigned, 18 bits wide.
 * Assumes a 250 MHz system clock and 16-bit unsigned converter samples.
 */
package pzs_pkg;

    // ------------------------------------------------------------------
    // Widths, limits and per-click amounts
    // ------------------------------------------------------------------
    localparam int MV_W = 18;
    localparam int ADC_W = 16;
    typedef logic [MV_W-1:0] pzs_mv_t;

    localparam pzs_mv_t LIM_75_MV = 18'h124F8;
    localparam pzs_mv_t LIM_100_MV = 18'h186A0;
    localparam pzs_mv_t LIM_150_MV = 18'h249F0;
    localparam pzs_mv_t RATE_HIGH_MV = 18'h003E8;
    localparam pzs_mv_t RATE_MED_MV = 18'h00064;
    localparam pzs_mv_t RATE_LOW_MV = 18'h0000A;
    localparam pzs_mv_t JOG_STEP_RST = 18'h00064;
    localparam pzs_mv_t JOG_STEP_INC = 18'h0000A;
    localparam pzs_mv_t JOG_STEP_MAX = 18'h02710;

    localparam logic [1:0] VMAX_75 = 2'h0;
    localparam logic [1:0] VMAX_100 = 2'h1;
    localparam logic [1:0] VMAX_150 = 2'h2;

    // ------------------------------------------------------------------
    // Modes and menu
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        IN_SMA = 2'h0, IN_HUB1 = 2'h1, IN_HUB2 = 2'h2, IN_OFF = 2'h3
    } pzs_in_t;
    typedef enum logic [1:0] {
        WM_ADJ = 2'h0, WM_JOG = 2'h1, WM_GOTO = 2'h2
    } pzs_wm_t;
    typedef enum logic [1:0] {
        RT_LOW = 2'h0, RT_MED = 2'h1, RT_HIGH = 2'h2
    } pzs_rate_t;
    typedef enum logic [3:0] {
        ST_MAIN = 4'h1, ST_LIST = 4'h2, ST_EDIT = 4'h4, ST_PARAM = 4'h8
    } pzs_st_t;

    localparam logic [3:0] OPT_FB = 4'h3;
    localparam logic [3:0] OPT_INPUT = 4'h4;
    localparam logic [3:0] OPT_WHEEL = 4'h5;
    localparam logic [3:0] OPT_PARAM = 4'h6;
    localparam logic [3:0] OPT_TEACH = 4'h7;

    localparam pzs_in_t RST_INPUT = IN_OFF;
    localparam pzs_wm_t RST_WHEEL = WM_ADJ;
    localparam pzs_rate_t RST_RATE = RT_MED;

    localparam logic [7:0] CH_S = 8'h53;
    localparam logic [7:0] CH_1 = 8'h31;
    localparam logic [7:0] CH_2 = 8'h32;
    localparam logic [7:0] CH_N = 8'h4E;
    localparam logic [7:0] CH_A = 8'h41;
    localparam logic [7:0] CH_J = 8'h4A;
    localparam logic [7:0] CH_G = 8'h47;
    localparam logic [6:0] PCT_FULL = 7'h64;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int CTRL_PERIOD_NS = 10000;
    localparam int CTRL_CYC = CTRL_PERIOD_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic up;
        logic dn;
    } pzs_click_t;

    typedef struct packed {
        pzs_mv_t value;
        logic is_pct;
        logic [7:0] in_char;
        logic [7:0] mode_char;
        logic [3:0] menu_item;
        logic in_menu;
    } pzs_disp_t;

endpackage : pzs_pkg

// file: rtl/pzs_wheel_dec.sv
/*
 * Wheel detent decoder: two-phase wheel contacts become single click
 * pulses with a direction. Assumes the contacts are asynchronous pins.
 */
`timescale 1ns/1ps
module pzs_wheel_dec import pzs_pkg::*; (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic wheel_a_i,
    input wire logic wheel_b_i,
    output pzs_click_t click_o
);
    logic [1:0] a_sync;
    logic [1:0] b_sync;
    logic a_last;
    wire a_rise = a_sync[1] & ~a_last;

    // --------------------------------------------------------------
    // Synchronise, then one click per rising edge of phase A
    // --------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            a_sync <= 2'h0;
            b_sync <= 2'h0;
            a_last <= 1'b0;
            click_o <= '0;
        end else begin
            a_sync <= {a_sync[0], wheel_a_i};
            b_sync <= {b_sync[0], wheel_b_i};
            a_last <= a_sync[1];
            click_o.up <= a_rise & ~b_sync[1];
            click_o.dn <= a_rise & b_sync[1];
        end
    end

    not_both_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        !(click_o.up && click_o.dn))
        else $error("Wheel click reported in both directions.");
endmodule : pzs_wheel_dec

// file: rtl/pzs_pi_loop.sv
/*
 * Proportional-integral position loop. Runs on a divided tick and keeps
 * the drive between zero and the hardware ceiling. Assumes the target and
 * feedback are both given in millivolt-equivalent units.
 */
`timescale 1ns/1ps
module pzs_pi_loop import pzs_pkg::*; #(
    parameter int TICK_CYC = CTRL_CYC,
    parameter int KP_SHIFT = 2,
    parameter int KI_SHIFT = 6
) (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic run_i,
    input pzs_mv_t target_i,
    input pzs_mv_t feedback_i,
    input pzs_mv_t ceiling_i,
    output pzs_mv_t drive_o
);
    initial begin
        if (TICK_CYC < 1 || TICK_CYC > 65536 || KP_SHIFT > 8 || KI_SHIFT > 12)
            $error("Loop parameters out of range.");
    end

    logic [15:0] tick_cnt;
    logic signed [31:0] integ;
    wire tick = (tick_cnt == 16'(TICK_CYC - 1));
    wire signed [31:0] err = 32'(signed'({1'b0, target_i}))
        - 32'(signed'({1'b0, feedback_i}));
    wire signed [31:0] int_max = 32'({1'b0, ceiling_i}) <<< KI_SHIFT;
    wire signed [31:0] int_sum = integ + err;
    wire signed [31:0] int_next = (int_sum < 0) ? 32'sh0 :
        (int_sum > int_max) ? int_max : int_sum;
    wire signed [31:0] raw = (err >>> KP_SHIFT) + (int_next >>> KI_SHIFT);
    wire pzs_mv_t next_drive = (raw < 0) ? '0 :
        (raw > 32'({1'b0, ceiling_i})) ? ceiling_i : raw[MV_W-1:0];

    // --------------------------------------------------------------
    // Loop update; integrator is held at zero while open
    // --------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tick_cnt <= 16'h0000;
            integ <= 32'sh0;
            drive_o <= '0;
        end else begin
            tick_cnt <= tick ? 16'h0000 : tick_cnt + 16'h0001;
            if (!run_i) begin
                integ <= 32'sh0;
                drive_o <= '0;
            end else if (tick) begin
                integ <= int_next;
                drive_o <= next_drive;
            end
        end
    end

    ceiling_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        run_i && tick |=> drive_o <= $past(ceiling_i))
        else $error("Loop drive exceeded ceiling.");
endmodule : pzs_pi_loop

// file: rtl/pzs_panel_ctrl.sv
/*
 * Front-panel setpoint controller of a piezo drive: menu, wheel modes,
 * teach levels, input routing and open/closed loop drive selection.
 * Assumes converter samples and control levels arrive on mclk_i; the
 * wheel contacts and menu button are asynchronous pins.
 */
// What this block does
// - Loop mode always starts open after power-up, never remembered.
// - Closed loop without feedback ramps drive to the hardware maximum.
// - The 100 V choice is software only; runaway still reaches 150 V.
// - Closed loop shows position as percent of travel instead of volts.
// - Input choices SMA, hub one, hub two, off shown as S, 1, 2, N.
// - Input off means no external input is used in open loop.
// - Open loop input drives amplifier; closed loop input is feedback.
// - Closed loop takes feedback from the selected input; off falls back to SMA.
// - Hub shared line spans all bays; pair line joins bays 1-2, 3-4, 5-6.
// - Closed loop with gauge reader applies no external modulation.
// - Jog mode moves setpoint one step per click in wheel direction.
// - Adjust mode moves 1 V, 100 mV or 10 mV per click by rate.
// - Go-to mode loads first teach level up, second teach level down.
// - Teach option copies setpoint into chosen slot, returns to main.
// - Wheel mode shown as A, J or G.
// - Options numbered 3 to 7; wheel scrolls, press enters.
// - Inside an option wheel changes candidate; press commits and exits, except in the parameter option.
// - Parameter option press opens step edit; next press stores jog step or rate, nothing in go-to mode.
// - Menu refused unless the high-voltage output is enabled.
// - Closed loop runs a proportional-integral position loop.
// - Open loop adds selected input to the internal setpoint.
`timescale 1ns/1ps
module pzs_panel_ctrl import pzs_pkg::*; #(
    parameter int CTRL_TICK_CYC = CTRL_CYC
) (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic wheel_a_i,
    input wire logic wheel_b_i,
    input wire logic menu_btn_i,
    input wire logic hv_enable_i,
    input wire logic [1:0] vmax_sel_i,
    input wire logic sg_reader_i,
    input wire logic [ADC_W-1:0] ext_sma_i,
    input wire logic [ADC_W-1:0] hub_shared_line_i,
    input wire logic [ADC_W-1:0] hub_pair_line_i,
    output pzs_mv_t drive_output_o,
    output pzs_mv_t setpoint_o,
    output pzs_mv_t first_teach_level_o,
    output pzs_mv_t second_teach_level_o,
    output pzs_mv_t jog_step_o,
    output logic loop_closed_o,
    output logic [1:0] input_sel_o,
    output logic [1:0] wheel_mode_o,
    output logic [1:0] adjust_rate_o,
    output pzs_disp_t disp_o
);
    default clocking chk_clk @(posedge mclk_i);
    endclocking
    default disable iff (!rstn_i);
    initial begin
        if (CTRL_TICK_CYC < 1)
            $error("Control tick must be at least one cycle.");
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic pzs_mv_t clamp_mv(input logic signed [19:0] v,
                                         input pzs_mv_t lim);
        if (v < 0)
            return '0;
        else if (v > signed'({2'b00, lim}))
            return lim;
        else
            return v[MV_W-1:0];
    endfunction : clamp_mv

    function automatic pzs_mv_t adc_to_mv(input logic [ADC_W-1:0] s,
                                          input pzs_mv_t lim);
        logic [33:0] p;
        p = 34'(s) * 34'(lim);
        return p[ADC_W +: MV_W];
    endfunction : adc_to_mv

    // ------------------------------------------------------------------
    // Inputs: wheel clicks and synchronised menu button
    // ------------------------------------------------------------------
    pzs_click_t click;
    logic [1:0] btn_sync;
    logic btn_last;
    wire press = btn_sync[1] & ~btn_last;
    wire turn = click.up | click.dn;

    pzs_wheel_dec u_wheel (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .wheel_a_i(wheel_a_i),
        .wheel_b_i(wheel_b_i),
        .click_o(click)
    );

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    pzs_st_t st;
    logic [3:0] item;
    logic [1:0] cand;
    pzs_mv_t pval;
    pzs_mv_t setpoint;
    pzs_mv_t teach1;
    pzs_mv_t teach2;
    pzs_mv_t jog_step;
    logic loop_closed;
    pzs_in_t in_sel;
    pzs_wm_t wmode;
    pzs_rate_t rate;

    // ------------------------------------------------------------------
    // Limits and setpoint arithmetic
    // ------------------------------------------------------------------
    // The 100 V choice only narrows the setpoint; the amplifier ceiling
    // stays at 150 V so a runaway loop can still reach it.
    wire pzs_mv_t cfg_lim = (vmax_sel_i == VMAX_75) ? LIM_75_MV :
        (vmax_sel_i == VMAX_100) ? LIM_100_MV : LIM_150_MV;
    wire pzs_mv_t hw_lim = (vmax_sel_i == VMAX_75) ? LIM_75_MV :
        LIM_150_MV;
    wire pzs_mv_t rate_amt = (rate == RT_HIGH) ? RATE_HIGH_MV :
        (rate == RT_MED) ? RATE_MED_MV : RATE_LOW_MV;
    wire pzs_mv_t step_amt = (wmode == WM_JOG) ? jog_step : rate_amt;
    wire signed [19:0] sp_s = signed'({2'b00, setpoint});
    wire signed [19:0] step_s = signed'({2'b00, step_amt});
    wire signed [19:0] sp_moved = click.up ? sp_s + step_s : sp_s - step_s;
    wire pzs_mv_t goto_val = click.up ? teach1 : teach2;
    wire pzs_mv_t sp_wheel = (wmode == WM_GOTO) ?
        clamp_mv(signed'({2'b00, goto_val}), cfg_lim) :
        clamp_mv(sp_moved, cfg_lim);
    wire pzs_mv_t sp_hold = clamp_mv(sp_s, cfg_lim);

    // ------------------------------------------------------------------
    // Candidate stepping inside the menu
    // ------------------------------------------------------------------
    wire [1:0] cand_top = (item == OPT_INPUT) ? 2'h3 :
        (item == OPT_WHEEL) ? 2'h2 : (item == OPT_PARAM) ? 2'h0 : 2'h1;
    wire [1:0] cand_up = (cand >= cand_top) ? cand_top : cand + 2'h1;
    wire [1:0] cand_dn = (cand == 2'h0) ? 2'h0 : cand - 2'h1;
    wire [1:0] next_cand = click.up ? cand_up : cand_dn;
    wire [1:0] cand_cur = (item == OPT_FB) ? {1'b0, loop_closed} :
        (item == OPT_INPUT) ? in_sel : (item == OPT_WHEEL) ? wmode : 2'h0;
    wire [3:0] item_up = (item == OPT_TEACH) ? OPT_FB : item + 4'h1;
    wire [3:0] item_dn = (item == OPT_FB) ? OPT_TEACH : item - 4'h1;
    wire pzs_mv_t pval_cur = (wmode == WM_JOG) ? jog_step :
        MV_W'(rate);
    wire pzs_mv_t pval_top = (wmode == WM_JOG) ? JOG_STEP_MAX :
        MV_W'(RT_HIGH);
    wire pzs_mv_t pval_inc = (wmode == WM_JOG) ? JOG_STEP_INC :
        MV_W'(1);
    wire pzs_mv_t pval_floor = (wmode == WM_JOG) ? JOG_STEP_INC : '0;
    wire pzs_mv_t next_pval = click.up ?
        ((pval >= pval_top - pval_inc) ? pval_top : pval + pval_inc) :
        ((pval <= pval_floor + pval_inc) ? pval_floor : pval - pval_inc);

    // ------------------------------------------------------------------
    // Menu and setpoint sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            btn_sync <= 2'h0;
            btn_last <= 1'b0;
            st <= ST_MAIN;
            item <= OPT_FB;
            cand <= 2'h0;
            pval <= '0;
            setpoint <= '0;
            teach1 <= '0;
            teach2 <= '0;
            jog_step <= JOG_STEP_RST;
            loop_closed <= 1'b0;
            in_sel <= RST_INPUT;
            wmode <= RST_WHEEL;
            rate <= RST_RATE;
        end else begin
            btn_sync <= {btn_sync[0], menu_btn_i};
            btn_last <= btn_sync[1];
            setpoint <= sp_hold;
            case (st)
                ST_MAIN: begin
                    if (press && hv_enable_i) begin
                        st <= ST_LIST;
                    end else if (turn) begin
                        setpoint <= sp_wheel;
                    end
                end
                ST_LIST: begin
                    if (press) begin
                        cand <= cand_cur;
                        st <= ST_EDIT;
                    end else if (turn) begin
                        item <= click.up ? item_up : item_dn;
                    end
                end
                ST_EDIT: begin
                    if (press) begin
                        st <= ST_MAIN;
                        case (item)
                            OPT_FB: loop_closed <= cand[0];
                            OPT_INPUT: in_sel <= pzs_in_t'(cand);
                            OPT_WHEEL: wmode <= (cand == 2'h3) ?
                                WM_GOTO : pzs_wm_t'(cand);
                            OPT_PARAM: begin
                                pval <= pval_cur;
                                st <= ST_PARAM;
                            end
                            OPT_TEACH: begin
                                if (cand == 2'h0)
                                    teach1 <= setpoint;
                                else
                                    teach2 <= setpoint;
                            end
                            default: st <= ST_MAIN;
                        endcase
                    end else if (turn) begin
                        cand <= next_cand;
                    end
                end
                ST_PARAM: begin
                    if (press) begin
                        st <= ST_MAIN;
                        if (wmode == WM_JOG)
                            jog_step <= pval;
                        else if (wmode == WM_ADJ)
                            rate <= pzs_rate_t'(pval[1:0]);
                    end else if (turn && wmode != WM_GOTO) begin
                        pval <= next_pval;
                    end
                end
                default: st <= ST_MAIN;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Routing and drive
    // ------------------------------------------------------------------
    // Hub pairing is fixed by the hub wiring, so only the line is chosen.
    wire [ADC_W-1:0] ext_sel = (in_sel == IN_HUB1) ? hub_shared_line_i :
        (in_sel == IN_HUB2) ? hub_pair_line_i : ext_sma_i;
    wire pzs_mv_t ext_mv = adc_to_mv(ext_sel, hw_lim);
    wire pzs_mv_t ext_add = (in_sel == IN_OFF) ? '0 : ext_mv;
    // In closed loop the off setting is overridden: the SMA input is used.
    wire pzs_mv_t fb_mv = ext_mv;
    wire pzs_mv_t open_drive = clamp_mv(
        sp_s + signed'({2'b00, ext_add}), hw_lim);
    pzs_mv_t pi_drive;

    pzs_pi_loop #(
        .TICK_CYC(CTRL_TICK_CYC)
    ) u_loop (
        .mclk_i(mclk_i),
        .rstn_i(rstn_i),
        .run_i(loop_closed),
        .target_i(setpoint),
        .feedback_i(fb_mv),
        .ceiling_i(hw_lim),
        .drive_o(pi_drive)
    );

    // Closed loop drive is the loop output alone, so nothing modulates it.
    wire pzs_mv_t next_drive = loop_closed ? pi_drive : open_drive;
    wire [ADC_W+6:0] pct_prod = 23'(ext_sel) * 23'(PCT_FULL);
    wire pzs_disp_t next_disp = '{
        value: loop_closed ? MV_W'(pct_prod[ADC_W +: 7]) : next_drive,
        is_pct: loop_closed,
        in_char: (in_sel == IN_SMA) ? CH_S : (in_sel == IN_HUB1) ? CH_1 :
            (in_sel == IN_HUB2) ? CH_2 : CH_N,
        mode_char: (wmode == WM_JOG) ? CH_J :
            (wmode == WM_GOTO) ? CH_G : CH_A,
        menu_item: item,
        in_menu: (st != ST_MAIN)
    };

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            drive_output_o <= '0;
            disp_o <= '0;
        end else begin
            drive_output_o <= next_drive;
            disp_o <= next_disp;
        end
    end

    assign setpoint_o = setpoint;
    assign first_teach_level_o = teach1;
    assign second_teach_level_o = teach2;
    assign jog_step_o = jog_step;
    assign loop_closed_o = loop_closed;
    assign input_sel_o = in_sel;
    assign wheel_mode_o = wmode;
    assign adjust_rate_o = rate;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence menu_try_s;
        st == ST_MAIN && press;
    endsequence

    boot_open_a: assert property ($rose(rstn_i) |-> !loop_closed)
        else $error("Loop not open after reset.");
    menu_lock_a: assert property (menu_try_s ##0 !hv_enable_i
        |=> st == ST_MAIN)
        else $error("Menu entered with output disabled.");
    sp_bound_a: assert property (##1 setpoint <= $past(cfg_lim))
        else $error("Setpoint above limit.");
    jog_click_a: assert property (st == ST_MAIN && !press
        && wmode == WM_JOG && click.up
        && 20'(setpoint) + 20'(jog_step) <= 20'(cfg_lim)
        |=> setpoint == $past(setpoint) + $past(jog_step))
        else $error("Jog click did not move one step.");
    goto_up_a: assert property (st == ST_MAIN && !press
        && wmode == WM_GOTO && click.up && teach1 <= cfg_lim
        |=> setpoint == $past(teach1))
        else $error("Go-to up did not load first teach level.");
    teach_one_a: assert property (st == ST_EDIT && press
        && item == OPT_TEACH && cand == 2'h0
        |=> teach1 == $past(setpoint) && st == ST_MAIN)
        else $error("Teach did not capture setpoint.");
    input_off_a: assert property (!loop_closed && in_sel == IN_OFF
        && setpoint <= hw_lim |=> drive_output_o == $past(setpoint))
        else $error("External input leaked with input off.");
    closed_drive_a: assert property (loop_closed
        |=> drive_output_o == $past(pi_drive))
        else $error("Closed loop drive not from loop.");
    show_mode_a: assert property (wmode == WM_JOG ##1 wmode == WM_JOG
        |-> disp_o.mode_char == CH_J)
        else $error("Jog mode character wrong.");
    pct_show_a: assert property (loop_closed |=> disp_o.is_pct)
        else $error("Closed loop not showing percent.");
endmodule : pzs_panel_ctrl

// file: bench/pzs_far_model.sv
/* Far-side model: operator wheel contacts and menu button.
   Assumes the bench calls its tasks and shares mclk_i. */
`timescale 1ns/1ps
module pzs_far_model (
    input wire logic mclk_i,
    output logic wheel_a_o,
    output logic wheel_b_o,
    output logic menu_btn_o
);
    initial begin
        wheel_a_o = 1'b0;
        wheel_b_o = 1'b0;
        menu_btn_o = 1'b0;
    end
    // Phase B settles before A rises, so the direction is never torn.
    task automatic click(input logic dn);
        @(negedge mclk_i) wheel_b_o = dn;
        @(negedge mclk_i) wheel_a_o = 1'b1;
        repeat (4) @(negedge mclk_i);
        wheel_a_o = 1'b0;
        repeat (6) @(negedge mclk_i);
    endtask : click
    task automatic press();
        @(negedge mclk_i) menu_btn_o = 1'b1;
        repeat (5) @(negedge mclk_i);
        menu_btn_o = 1'b0;
        repeat (6) @(negedge mclk_i);
    endtask : press
endmodule : pzs_far_model

// file: bench/tb_top.sv
/* Self-checking bench of the panel controller.
   Assumes the far-side model drives the wheel and button pins. */
`timescale 1ns/1ps
module tb_top import pzs_pkg::*; ();
    // --------------------------------------------------------------
    // Signals and instances
    // --------------------------------------------------------------
    logic mclk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic hv_en = 1'b0;
    logic sg_rd = 1'b1;
    logic [1:0] vmax = 2'h2;
    logic [15:0] sma = 16'h8000;
    logic [15:0] hub1 = 16'h4000;
    logic [15:0] hub2 = 16'h2000;
    wire logic wa, wb, btn;
    pzs_mv_t drv, sp, t1, t2, js;
    logic lc;
    logic [1:0] ins, wm, ar;
    pzs_disp_t dsp;
    int failures = 0;
    int checked = 0;
    int cyc = 0;
    always #2 mclk_i = ~mclk_i;
    pzs_far_model pzs_far_model_inst (.mclk_i(mclk_i), .wheel_a_o(wa),
        .wheel_b_o(wb), .menu_btn_o(btn));
    // Each input carries a distinct live level so a wrong route shows up.
    pzs_panel_ctrl #(.CTRL_TICK_CYC(4)) pzs_panel_ctrl_inst (
        .mclk_i(mclk_i), .rstn_i(rstn_i), .wheel_a_i(wa), .wheel_b_i(wb),
        .menu_btn_i(btn), .hv_enable_i(hv_en), .vmax_sel_i(vmax),
        .sg_reader_i(sg_rd), .ext_sma_i(sma),
        .hub_shared_line_i(hub1), .hub_pair_line_i(hub2),
        .drive_output_o(drv), .setpoint_o(sp), .first_teach_level_o(t1),
        .second_teach_level_o(t2), .jog_step_o(js), .loop_closed_o(lc),
        .input_sel_o(ins), .wheel_mode_o(wm), .adjust_rate_o(ar),
        .disp_o(dsp));
    // --------------------------------------------------------------
    // Tasks
    // --------------------------------------------------------------
    task automatic chk_mv(input pzs_mv_t got, input pzs_mv_t exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_mv
    task automatic chk_fld(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_fld
    task automatic menu(input int items, input int n, input logic dn);
        pzs_far_model_inst.press();
        repeat (items) pzs_far_model_inst.click(1'b0);
        pzs_far_model_inst.press();
        repeat (n) pzs_far_model_inst.click(dn);
        pzs_far_model_inst.press();
    endtask : menu
    task automatic complete_run();
        if (failures == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : complete_run
    // The whole sequence needs under 2000 cycles.
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            complete_run();
        end
    end
    // --------------------------------------------------------------
    // Sequence
    // --------------------------------------------------------------
    initial begin
        repeat (8) @(negedge mclk_i);
        rstn_i = 1'b1;
        repeat (2) @(negedge mclk_i);
        chk_fld({7'h00, lc}, 8'h00);
        chk_fld({6'h00, ins}, {6'h00, RST_INPUT});
        chk_fld(dsp.in_char, CH_N);
        chk_fld(dsp.mode_char, CH_A);
        chk_mv(js, JOG_STEP_RST);
        chk_fld({6'h00, ar}, {6'h00, RST_RATE});
        pzs_far_model_inst.press();
        pzs_far_model_inst.click(1'b0);
        chk_fld({7'h00, dsp.in_menu}, 8'h00);
        chk_mv(sp, RATE_MED_MV);
        chk_mv(drv, RATE_MED_MV);
        repeat (2) pzs_far_model_inst.click(1'b1);
        chk_mv(sp, 18'h00000);
        pzs_far_model_inst.click(1'b0);
        hv_en = 1'b1;
        menu(1, 3, 1'b1);
        chk_fld({6'h00, ins}, {6'h00, IN_SMA});
        chk_fld(dsp.in_char, CH_S);
        chk_mv(drv, RATE_MED_MV + (LIM_150_MV >> 1));
        menu(0, 1, 1'b0);
        chk_fld(dsp.in_char, CH_1);
        chk_mv(drv, RATE_MED_MV + (LIM_150_MV >> 2));
        menu(0, 1, 1'b0);
        chk_mv(drv, RATE_MED_MV + (LIM_150_MV >> 3));
        // A 100 V choice must not clip the amplifier below 150 V.
        vmax = 2'h1;
        hub2 = 16'hFFFF;
        repeat (2) @(negedge mclk_i);
        chk_mv(drv, LIM_150_MV);
        hub2 = 16'h2000;
        menu(2, 0, 1'b0);
        pzs_far_model_inst.click(1'b0);
        pzs_far_model_inst.press();
        chk_fld({6'h00, ar}, {6'h00, RT_HIGH});
        pzs_far_model_inst.click(1'b0);
        chk_mv(sp, RATE_MED_MV + RATE_HIGH_MV);
        pzs_far_model_inst.click(1'b1);
        menu(4, 1, 1'b0);
        chk_fld(dsp.mode_char, CH_J);
        menu(1, 0, 1'b0);
        pzs_far_model_inst.click(1'b0);
        pzs_far_model_inst.press();
        chk_mv(js, JOG_STEP_RST + JOG_STEP_INC);
        pzs_far_model_inst.click(1'b0);
        chk_mv(sp, RATE_MED_MV + JOG_STEP_RST + JOG_STEP_INC);
        menu(1, 0, 1'b0);
        chk_mv(t1, RATE_MED_MV + JOG_STEP_RST + JOG_STEP_INC);
        chk_fld({7'h00, dsp.in_menu}, 8'h00);
        pzs_far_model_inst.click(1'b1);
        chk_mv(sp, RATE_MED_MV);
        menu(0, 1, 1'b0);
        chk_mv(t2, RATE_MED_MV);
        menu(3, 1, 1'b0);
        chk_fld({6'h00, wm}, {6'h00, WM_GOTO});
        chk_fld(dsp.mode_char, CH_G);
        pzs_far_model_inst.click(1'b0);
        chk_mv(sp, RATE_MED_MV + JOG_STEP_RST + JOG_STEP_INC);
        pzs_far_model_inst.click(1'b1);
        chk_mv(sp, RATE_MED_MV);
        menu(3, 1, 1'b0);
        chk_fld({7'h00, lc}, 8'h01);
        chk_fld({7'h00, dsp.is_pct}, 8'h01);
        chk_mv(dsp.value, MV_W'(PCT_FULL >> 3));
        chk_mv(drv, 18'h00000);
        complete_run();
    end
endmodule : tb_top
